// >>> src/phase_step_and_page_regs.sv
// Phase step limit, divider masks, host guard and page select registers
//
// Behaviour
// - Eight-bit step limit, percent of output period, caps each phase step.
// - Low mask: bits 1:0 synth 0 A-B, bits 7:4 synth 1 A-D.
// - High mask: bits 3:0 synth 2 A-D, bits 5:4 synth 3 A-B.
// - Lockout set makes every other host register read-only.
// - Guard bit 0 flags a failed host access, bit 7 reads lockout; bits 6:1 read zero.
// - Page select picks 128-byte page; 7, 9 reserved, 0-13 otherwise valid.
// - Device clears command field after capture; host writes nonzero only when zero.
// - Command 00 idle, 01 reset, 10 read offset, 11 cumulative write.
// - Step data 32-bit two's complement, MSB at lowest address, 1.25 ns units.
`timescale 1ns/1ps
`include "phase_step_defs.svh"

module phase_step_and_page_regs
	import phase_step_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [6:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	output logic shift_req_out,
	output shift_request_type shift_request_out,
	input wire logic shift_done_in,
	input wire logic [31:0] shift_result_in
);

	// ------------------------------------------------------------------------
	// Address forming
	// ------------------------------------------------------------------------
	function automatic logic [14:0] full_address(input logic [7:0] page,
		input logic [6:0] offset);
		full_address = {page, offset};
	endfunction : full_address

	function automatic logic page_valid(input logic [7:0] page);
		page_valid = (page <= `PAGE_LAST) && (page != `PAGE_RSVD_A) &&
			(page != `PAGE_RSVD_B);
	endfunction : page_valid

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	state_type state_q;
	state_type state_d;
	logic [14:0] addr;
	logic global_hit;
	logic access;
	logic fail;
	logic locked_wr;

	// ------------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------------
	always_comb begin
		// Guard and page select sit at the top of every page so a bad page
		// can always be left again
		global_hit = (reg_addr_in == `GUARD_OFFSET) || (reg_addr_in == `PAGE_OFFSET);
		if (global_hit) begin
			addr = {`GLOBAL_PAGE, reg_addr_in};
		end else begin
			addr = full_address(state_q.page, reg_addr_in);
		end
	end

	always_comb begin
		state_d = state_q;
		access = reg_wr_in || reg_rd_in;
		// Guard stays writable so the lockout can be lifted again
		locked_wr = reg_wr_in && state_q.lockout && (addr != `GUARD_ADDR);
		fail = 1'b0;

		// --------------------------------------------------------------------
		// Engine handshake: capture done, command field back to idle
		// --------------------------------------------------------------------
		if (shift_done_in && (state_q.code != CMD_IDLE)) begin
			// Offset read lands in the step data bytes for the host to fetch
			if (state_q.code == CMD_READ) begin
				state_d.data = shift_result_in;
			end
			state_d.code = CMD_IDLE;
		end

		// --------------------------------------------------------------------
		// Register access
		// --------------------------------------------------------------------
		// Read data stands one cycle, then falls back to zero
		state_d.rdata = `BYTE_RESET;
		// Reserved or missing pages flag a failure instead of aliasing
		if (access && !global_hit && !page_valid(state_q.page)) begin
			fail = 1'b1;
		end else if (locked_wr) begin
			fail = 1'b1;
		end else if (access) begin
			case (addr)
				`CTRL_ADDR: begin
					state_d.rdata = {state_q.select, 2'b00, state_q.code};
					if (reg_wr_in) begin
						// A command over one in flight would race the engine
						if (state_q.code != CMD_IDLE) begin
							fail = 1'b1;
						end else begin
							state_d.select = reg_wdata_in[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
							state_d.code = shift_command_type'(
								reg_wdata_in[`CTRL_CODE_MSB:0]);
						end
					end
				end
				`DATA_B3_ADDR: begin
					state_d.rdata = state_q.data[31:24];
					if (reg_wr_in) begin
						state_d.data[31:24] = reg_wdata_in;
					end
				end
				`DATA_B2_ADDR: begin
					state_d.rdata = state_q.data[23:16];
					if (reg_wr_in) begin
						state_d.data[23:16] = reg_wdata_in;
					end
				end
				`DATA_B1_ADDR: begin
					state_d.rdata = state_q.data[15:8];
					if (reg_wr_in) begin
						state_d.data[15:8] = reg_wdata_in;
					end
				end
				`DATA_B0_ADDR: begin
					state_d.rdata = state_q.data[7:0];
					if (reg_wr_in) begin
						state_d.data[7:0] = reg_wdata_in;
					end
				end
				`LIMIT_ADDR: begin
					state_d.rdata = state_q.limit;
					if (reg_wr_in) begin
						// Stored as written; the range is the host's to keep
						state_d.limit = reg_wdata_in;
					end
				end
				`MASK_LOW_ADDR: begin
					state_d.rdata = state_q.mask_low;
					if (reg_wr_in) begin
						state_d.mask_low = reg_wdata_in & `MASK_LOW_USED;
					end
				end
				`MASK_HIGH_ADDR: begin
					state_d.rdata = state_q.mask_high;
					if (reg_wr_in) begin
						state_d.mask_high = reg_wdata_in & `MASK_HIGH_USED;
					end
				end
				`GUARD_ADDR: begin
					state_d.rdata = {state_q.lockout, 6'h00, state_q.status};
					if (reg_wr_in) begin
						state_d.lockout = reg_wdata_in[`GUARD_LOCK_BIT];
						if (reg_wdata_in[`GUARD_STATUS_BIT]) begin
							state_d.status = 1'b0;
						end
					end
				end
				`PAGE_ADDR: begin
					state_d.rdata = state_q.page;
					if (reg_wr_in) begin
						state_d.page = reg_wdata_in;
					end
				end
				default: begin
					// Holes in the page count as failed accesses
					fail = 1'b1;
				end
			endcase
		end

		// New failure wins over a clear in the same cycle
		if (fail) begin
			state_d.status = 1'b1;
		end
	end

	// ------------------------------------------------------------------------
	// Register update
	// ------------------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			// Field by field so the reset branch holds only constants
			state_q.code <= CMD_IDLE;
			state_q.select <= `SELECT_RESET;
			state_q.data <= `DATA_RESET;
			state_q.limit <= `BYTE_RESET;
			state_q.mask_low <= `BYTE_RESET;
			state_q.mask_high <= `BYTE_RESET;
			state_q.lockout <= 1'b0;
			state_q.status <= 1'b0;
			state_q.page <= `BYTE_RESET;
			state_q.rdata <= `BYTE_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign reg_rdata_out = state_q.rdata;
	assign shift_req_out = (state_q.code != CMD_IDLE);
	assign shift_request_out = '{
		shift_command_code: state_q.code,
		output_select: state_q.select,
		step_data: state_q.data,
		limit_percent: state_q.limit,
		mask_low: state_q.mask_low,
		mask_high: state_q.mask_high
	};

endmodule : phase_step_and_page_regs

// >>> src/phase_step_defs.svh
// Address map, field positions and reset values of the phase step and page registers
`ifndef PHASE_STEP_DEFS_SVH
`define PHASE_STEP_DEFS_SVH

// ----------------------------------------------------------------------------
// Internal byte addresses (page * 128 + in-page offset)
// ----------------------------------------------------------------------------
`define CTRL_ADDR 15'h0501
`define DATA_B3_ADDR 15'h0502
`define DATA_B2_ADDR 15'h0503
`define DATA_B1_ADDR 15'h0504
`define DATA_B0_ADDR 15'h0505
`define LIMIT_ADDR 15'h0506
`define MASK_LOW_ADDR 15'h0510
`define MASK_HIGH_ADDR 15'h0511
`define GUARD_ADDR 15'h057E
`define PAGE_ADDR 15'h057F

// ----------------------------------------------------------------------------
// In-page offsets reached from every page
// ----------------------------------------------------------------------------
`define GUARD_OFFSET 7'h7E
`define PAGE_OFFSET 7'h7F
`define GLOBAL_PAGE 8'h0A

// ----------------------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------------------
`define MASK_LOW_USED 8'hF3
`define MASK_HIGH_USED 8'h3F
`define GUARD_LOCK_BIT 7
`define GUARD_STATUS_BIT 0
`define CTRL_CODE_MSB 1
`define CTRL_SEL_LSB 4
`define CTRL_SEL_MSB 7
`define PAGE_RSVD_A 8'h07
`define PAGE_RSVD_B 8'h09
`define PAGE_LAST 8'h0D

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define BYTE_RESET 8'h00
`define DATA_RESET 32'h0000_0000
`define SELECT_RESET 4'h0

`endif

// >>> src/phase_step_pkg.sv
// Types shared by the phase step and page register slice
package phase_step_pkg;

	typedef enum logic [1:0] {
		CMD_IDLE = 2'b00,
		CMD_RESET = 2'b01,
		CMD_READ = 2'b10,
		CMD_WRITE = 2'b11
	} shift_command_type;

	typedef struct packed {
		shift_command_type shift_command_code;
		logic [3:0] output_select;
		logic [31:0] step_data;
		logic [7:0] limit_percent;
		logic [7:0] mask_low;
		logic [7:0] mask_high;
	} shift_request_type;

	typedef struct packed {
		shift_command_type code;
		logic [3:0] select;
		logic [31:0] data;
		logic [7:0] limit;
		logic [7:0] mask_low;
		logic [7:0] mask_high;
		logic lockout;
		logic status;
		logic [7:0] page;
		logic [7:0] rdata;
	} state_type;

endpackage : phase_step_pkg

// >>> test/phase_step_and_page_regs_tb.sv
// Self-checking bench for the phase step register slice
`timescale 1ns/1ps
module phase_step_and_page_regs_tb;
	import phase_step_pkg::*;
	localparam logic [31:0] RES = 32'hFEDC_BA98;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [6:0] reg_addr_in = 7'h00;
	logic [7:0] reg_wdata_in = 8'h00;
	logic [7:0] reg_rdata_out;
	logic shift_req_out;
	shift_request_type shift_request_out;
	logic shift_done_in;
	logic [31:0] shift_result_in;
	int failures = 0;
	int comparisons = 0;
	logic [31:0] d = 32'h1234_5678;
	logic [7:0] pg [4] = '{8'h07, 8'h09, 8'h0B, 8'h0E};
	shift_command_type cmd [3] = '{CMD_WRITE, CMD_RESET, CMD_READ};
	always #20 clk_in = ~clk_in;
	phase_step_and_page_regs uut (.*);
	shift_engine_model #(.RESULT(RES)) eng (.clk_in(clk_in), .req_in(shift_req_out),
		.done_out(shift_done_in), .result_out(shift_result_in));
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task wr_reg(input logic [6:0] a, input logic [7:0] v);
		@(negedge clk_in);
		reg_wr_in = 1'b1;
		reg_addr_in = a;
		reg_wdata_in = v;
		@(negedge clk_in);
		reg_wr_in = 1'b0;
	endtask : wr_reg
	task rc(input logic [6:0] a, input logic [7:0] e);
		@(negedge clk_in);
		reg_rd_in = 1'b1;
		reg_addr_in = a;
		@(negedge clk_in);
		reg_rd_in = 1'b0;
		chk(reg_rdata_out, e);
	endtask : rc
	task tally_and_finish;
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		#400000;
		failures++;
		tally_and_finish();
	end
	initial begin
		repeat (2) @(negedge clk_in);
		rst_b_in = 1'b1;
		rc(7'h7E, 8'h00);
		rc(7'h7F, 8'h00);
		wr_reg(7'h7F, 8'h0A);
		rc(7'h06, 8'h00);
		wr_reg(7'h06, 8'h31);
		rc(7'h06, 8'h31);
		wr_reg(7'h10, 8'hFF);
		rc(7'h10, 8'hF3);
		wr_reg(7'h11, 8'hFF);
		rc(7'h11, 8'h3F);
		// Each page here misses the limit register, so the write must bounce
		foreach (pg[i]) begin
			wr_reg(7'h7F, pg[i]);
			rc(7'h7F, pg[i]);
			wr_reg(7'h06, 8'h05);
			rc(7'h7E, 8'h01);
			wr_reg(7'h7E, 8'h01);
			wr_reg(7'h7F, 8'h0A);
			rc(7'h7E, 8'h00);
			rc(7'h06, 8'h31);
		end
		wr_reg(7'h7E, 8'h80);
		wr_reg(7'h06, 8'h01);
		wr_reg(7'h7F, 8'h00);
		rc(7'h06, 8'h31);
		rc(7'h7E, 8'h81);
		wr_reg(7'h7E, 8'h01);
		wr_reg(7'h06, 8'h01);
		rc(7'h06, 8'h01);
		for (int i = 0; i < 4; i++)
			wr_reg(7'(2 + i), d[31 - 8 * i -: 8]);
		foreach (cmd[i]) begin
			wr_reg(7'h01, {4'h1, 2'b00, cmd[i]});
			chk(shift_request_out.shift_command_code, cmd[i]);
			chk(shift_request_out.step_data, d);
			chk(shift_request_out.limit_percent, 8'h01);
			chk(shift_request_out.mask_low, 8'hF3);
			chk(shift_request_out.mask_high, 8'h3F);
			chk(shift_request_out.output_select, 4'h1);
			for (int n = 0; n < 20 && shift_req_out; n++)
				@(negedge clk_in);
			chk(shift_req_out, 1'b0);
			rc(7'h01, 8'h10);
		end
		// A command written while one is in flight must bounce
		wr_reg(7'h01, 8'h13);
		wr_reg(7'h01, 8'h12);
		chk(shift_request_out.shift_command_code, CMD_WRITE);
		for (int n = 0; n < 20 && shift_req_out; n++)
			@(negedge clk_in);
		rc(7'h7E, 8'h01);
		wr_reg(7'h7E, 8'h01);
		rc(7'h01, 8'h10);
		for (int i = 0; i < 4; i++)
			rc(7'(2 + i), RES[31 - 8 * i -: 8]);
		tally_and_finish();
	end
endmodule : phase_step_and_page_regs_tb

// >>> test/phase_step_checker.sv
// Port assertions for the phase step register slice
`timescale 1ns/1ps
module phase_step_checker
	import phase_step_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [6:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic shift_req_out,
	input wire shift_request_type shift_request_out,
	input wire logic shift_done_in
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);
	rdata_idle_a: assert property (!$past(reg_rd_in) && !$past(reg_wr_in)
		|-> reg_rdata_out == 8'h00) else $error("rdata not idle");
	limit_hold_a: assert property (!reg_wr_in
		|=> $stable(shift_request_out.limit_percent)) else $error("limit moved");
	done_clears_a: assert property (shift_req_out && shift_done_in |=> !shift_req_out)
		else $error("req not cleared");
	req_hold_a: assert property (shift_req_out && !shift_done_in && !reg_wr_in
		|=> $stable(shift_request_out)) else $error("req moved");
	req_start_a: assert property ($rose(shift_req_out)
		|-> $past(reg_wr_in) && $past(reg_addr_in) == 7'h01) else $error("req start");
	cmd_code_a: assert property ($rose(shift_req_out)
		|-> shift_request_out.shift_command_code == $past(reg_wdata_in[1:0])) else $error("cmd");
	low_rsvd_a: assert property (shift_request_out.mask_low[3:2] == 2'h0)
		else $error("low mask");
	high_rsvd_a: assert property (shift_request_out.mask_high[7:6] == 2'h0)
		else $error("high mask");
endmodule : phase_step_checker

bind phase_step_and_page_regs phase_step_checker chk_i (.*);

// >>> test/shift_engine_model.sv
// Behavioural phase step engine answering capture requests
`timescale 1ns/1ps
module shift_engine_model #(
	parameter logic [31:0] RESULT = 32'h0F0F_A5A5
) (
	input wire logic clk_in,
	input wire logic req_in,
	output logic done_out,
	output logic [31:0] result_out
);
	logic [1:0] cnt = 2'h0;
	initial done_out = 1'b0;
	initial result_out = ~RESULT;
	// Result toggles outside done so a stale sample cannot pass
	always @(posedge clk_in) begin
		cnt <= req_in ? cnt + 2'h1 : 2'h0;
		done_out <= req_in && cnt == 2'h1;
		result_out <= (req_in && cnt == 2'h1) ? RESULT : ~result_out;
	end
endmodule : shift_engine_model
